// ==== rtl/acs_sequencer.sv ====
// Purpose: APB-controlled sequencer for a ten-bit successive-approximation converter
// Assumes: comparator answer is synchronous to pclk; rc_tick is a one-cycle pulse per R-C period
// Notes: E-clock equals pclk qualified by clk_en
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module acs_sequencer
#(
	parameter int PWR_SETTLE_CYC = `ACS_PWR_SETTLE_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rc_tick,
	input wire logic low_power,
	input wire logic cmp_above,
	output acs_pkg::acs_ana_t analog_out
);
	import acs_pkg::*;

	// register map and bus decode
	logic hit_ctl;
	logic hit_rate;
	logic hit_opt;
	logic hit_res;
	logic hit_any;
	logic xfer;
	logic wr_ctl;
	logic acc_first;
	logic [7:0] word_idx;

	acs_ctl_t ctl;
	logic done_flag;
	logic half_rate_select;
	logic converter_power_on;
	logic conversion_clock_source;
	logic stop_exit_delay;
	logic pwr_ready;
	logic [$clog2(PWR_SETTLE_CYC + 1)-1:0] pwr_cnt;

	// sequencing
	acs_state_t state;
	logic [5:0] phase;
	logic [2:0] conv_idx;
	logic e_half;
	logic tick;
	logic last_phase;
	logic [3:0] cur_chan;
	logic [2:0] cur_slot;
	logic store;
	logic pass_end;
	logic [2:0] rd_slot;
	logic [9:0] rd_data;
	logic [31:0] next_prdata;

	function automatic logic [3:0] chan_of(input acs_ctl_t c, input logic [2:0] k);
		if (!c.multi)
			chan_of = c.chan;
		else if (c.eight_conversion_select)
			chan_of = {c.chan[3], k}; // RULE3 RULE18
		else
			chan_of = {c.chan[3:2], k[1:0]}; // RULE3 RULE18
	endfunction

	function automatic logic [2:0] slot_of(input acs_ctl_t c, input logic [2:0] k);
		if (c.eight_conversion_select)
			slot_of = k; // RULE1 RULE6
		else
			slot_of = {1'b1, k[1:0]}; // RULE4 RULE25
	endfunction

	function automatic logic is_last(input acs_ctl_t c, input logic [2:0] k);
		is_last = (k == {c.eight_conversion_select, 2'h3});
	endfunction

	function automatic logic idx_hit(input logic [11:0] a, input logic [7:0] idx);
		idx_hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) && (a[9:2] == idx);
	endfunction

	assign word_idx = paddr[9:2];
	assign hit_ctl = idx_hit(paddr, `ACS_IDX_CTL);
	assign hit_rate = idx_hit(paddr, `ACS_IDX_RATE);
	assign hit_opt = idx_hit(paddr, `ACS_IDX_OPT);
	assign hit_res = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0)
		&& (word_idx >= `ACS_IDX_RES_FIRST) && (word_idx <= `ACS_IDX_RES_LAST);
	assign hit_any = hit_ctl || hit_rate || hit_opt || hit_res;
	assign xfer = psel && penable && pready;
	assign wr_ctl = xfer && pwrite && hit_ctl;
	assign acc_first = psel && penable && !pready;

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else if (clk_en)
			pready <= acc_first;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else if (clk_en)
			pslverr <= acc_first && !hit_any;
	end

	// result slot i: high byte at even index, low bits at odd index
	assign rd_slot = word_idx[3:1];

	always_comb
	begin
		next_prdata = 32'h0000_0000;
		if (hit_ctl)
			next_prdata[7:0] = {done_flag, ctl}; // RULE17
		else if (hit_rate)
			next_prdata[7:0] = {7'h00, half_rate_select}; // RULE20
		else if (hit_opt)
		begin
			next_prdata[`ACS_BIT_PWR] = converter_power_on;
			next_prdata[`ACS_BIT_CONVERSION_CLOCK_SOURCE] = conversion_clock_source;
			next_prdata[`ACS_BIT_DLY] = stop_exit_delay;
			next_prdata[`ACS_BIT_READY] = pwr_ready;
		end
		else if (hit_res)
		begin
			if (word_idx[0])
				next_prdata[7:0] = {rd_data[1:0], 6'h00}; // RULE26
			else
				next_prdata[7:0] = rd_data[9:2]; // RULE26
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (clk_en && acc_first && !pwrite)
			prdata <= next_prdata;
	end

	// software-visible registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctl <= acs_ctl_t'(7'(`ACS_RST_CTL));
		else if (clk_en && wr_ctl)
			ctl <= acs_ctl_t'(pwdata[6:0]); // RULE15
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			half_rate_select <= 1'(`ACS_RST_RATE); // RULE19
		else if (clk_en && xfer && pwrite && hit_rate)
			half_rate_select <= pwdata[`ACS_BIT_HALF]; // RULE19
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			converter_power_on <= 1'b0;
			conversion_clock_source <= 1'b0;
			stop_exit_delay <= 1'b0;
		end
		else if (clk_en && xfer && pwrite && hit_opt)
		begin
			converter_power_on <= pwdata[`ACS_BIT_PWR]; // RULE9
			conversion_clock_source <= pwdata[`ACS_BIT_CONVERSION_CLOCK_SOURCE]; // RULE10
			stop_exit_delay <= pwdata[`ACS_BIT_DLY];
		end
	end

	// settling indicator; software still owns the wait
	// status only: conversions are not gated by it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwr_cnt <= '0;
			pwr_ready <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!converter_power_on)
			begin
				pwr_cnt <= '0;
				pwr_ready <= 1'b0;
			end
			else if (pwr_cnt == PWR_SETTLE_CYC[$bits(pwr_cnt)-1:0])
				pwr_ready <= 1'b1; // RULE9
			else
				pwr_cnt <= pwr_cnt + 1'b1;
		end
	end

	// conversion clock: E, E/2 or R-C pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			e_half <= 1'b0;
		else if (clk_en)
			e_half <= !e_half;
	end

	// the R-C pulse ignores the half rate bit entirely
	assign tick = conversion_clock_source ? rc_tick : (!half_rate_select || e_half); // RULE10 RULE22 RULE24
	assign last_phase = (phase == 6'(`ACS_CONV_TICKS - 1)); // RULE23
	assign cur_chan = chan_of(ctl, conv_idx);
	assign cur_slot = slot_of(ctl, conv_idx);
	assign store = (state == ACS_RUN) && tick && last_phase && !low_power && !wr_ctl;
	assign pass_end = is_last(ctl, conv_idx);

	// sequence state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ACS_IDLE; // RULE27
		else if (clk_en)
		begin
			// a write with power off must not leave a stray sample pulse
			if (wr_ctl && converter_power_on)
				state <= ACS_RUN; // RULE15
			else if (!converter_power_on)
				state <= ACS_IDLE; // RULE9
			else
			begin
				unique case (state)
					ACS_IDLE:
						state <= ACS_IDLE;
					ACS_RUN:
					begin
						if (low_power)
							state <= ACS_HOLD; // RULE13
						else if (store && !ctl.scan && pass_end)
							state <= ACS_IDLE; // RULE1 RULE4 RULE6 RULE8
					end
					ACS_HOLD:
					begin
						if (!low_power)
							state <= ACS_RUN; // RULE13
					end
					default:
						state <= ACS_IDLE;
				endcase
			end
		end
	end

	// phase within one conversion; suspension restarts the current channel
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase <= 6'h00;
		else if (clk_en)
		begin
			if (wr_ctl || state != ACS_RUN || low_power)
				phase <= 6'h00; // RULE13 RULE15
			else if (tick)
				phase <= last_phase ? 6'h00 : phase + 6'h01;
		end
	end

	// position in the pass; wraps so continuous scan rotates through the slots
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			conv_idx <= 3'h0;
		else if (clk_en)
		begin
			if (wr_ctl)
				conv_idx <= 3'h0; // RULE15
			else if (store)
			begin
				if (pass_end)
					conv_idx <= 3'h0; // RULE2 RULE5 RULE7
				else
					conv_idx <= conv_idx + 3'h1;
			end
		end
	end

	// the write wins over a pass ending in the same cycle, as that pass is aborted
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done_flag <= 1'b0;
		else if (clk_en)
		begin
			if (wr_ctl)
				done_flag <= 1'b0; // RULE15
			else if (store && pass_end)
				done_flag <= 1'b1; // RULE16
		end
	end

	// analog side: channel, sample window and successive approximation
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			analog_out <= '0;
		else if (clk_en)
		begin
			analog_out.power_en <= converter_power_on; // RULE9
			analog_out.channel <= cur_chan;
			analog_out.sample <= (state == ACS_RUN) && !low_power
				&& (phase < 6'(`ACS_SAMPLE_TICKS));
			// set the trial bit, keep it next tick only if the input is at or above it
			if (state == ACS_RUN && tick && !low_power)
			begin
				if (phase == 6'h00)
					analog_out.dac_code <= 10'h000;
				if (phase > 6'(`ACS_SAMPLE_TICKS)
					&& phase <= 6'(`ACS_SAMPLE_TICKS + `ACS_RES_BITS) && !cmp_above)
					analog_out.dac_code[4'(`ACS_SAMPLE_TICKS + `ACS_RES_BITS) - 4'(phase)] <= 1'b0;
				if (phase >= 6'(`ACS_SAMPLE_TICKS)
					&& phase < 6'(`ACS_SAMPLE_TICKS + `ACS_RES_BITS))
					analog_out.dac_code[4'(`ACS_SAMPLE_TICKS + `ACS_RES_BITS - 1) - 4'(phase)] <= 1'b1;
			end
		end
	end

	acs_result_bank u_bank
	(
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.wr_en(store),
		.wr_slot(cur_slot),
		.wr_data(analog_out.dac_code),
		.rd_slot(rd_slot),
		.rd_data(rd_data)
	);
endmodule // acs_sequencer
`default_nettype wire

// ==== rtl/acs_params.svh ====
// Purpose: constants for the conversion sequencer (offsets, fields, resets, timing)
// Assumes: APB byte address is four times the register index
// Notes: definitions only
// Contract
// RULE1 - single channel, eight conversions, single scan: slots 1..8 in order, then stop
// RULE2 - single channel, eight conversions, continuous: ninth result wraps to slot 1
// RULE3 - multi channel: group chosen by top two select bits (4) or top bit (8)
// RULE4 - four channel single scan: results in slots 5..8 in channel order, then halt
// RULE5 - four channel continuous: fifth conversion overwrites slot 5, rotating forever
// RULE6 - eight channel single scan: each group channel once, own slot by position, halt
// RULE7 - eight channel continuous: ninth conversion overwrites slot 1, rotating forever
// RULE8 - scan bit set gives continuous; clear gives four or eight conversions then stop
// RULE9 - power bit clear removes converter power; software waits 100 us after enabling
// RULE10 - clock source bit clear selects E-clock, set selects internal R-C oscillator
// RULE11 - software waits 10 ms after selecting the R-C oscillator before converting
// RULE12 - software selects the R-C oscillator whenever E-clock is below 750 kHz
// RULE13 - low-power entry suspends current channel; resume re-samples it and continues
// RULE14 - fast stop exit with external clock: software allows about 100 us
// RULE15 - control write clears done flag, aborts conversion, restarts with new settings
// RULE16 - done flag bit 7 sets after a full pass; stays set until control is written
// RULE17 - control bits: done 7, eight 6, scan 5, multi 4, channel select 3..0
// RULE18 - multi mode ignores low two select bits (four) or low three bits (eight)
// RULE19 - rate bit 0 set selects E/2, clear selects E; rate register resets to zero
// RULE20 - rate register bits 7..1 are unimplemented and read zero
// RULE21 - software should set half rate when bus frequency exceeds 2.1 MHz
// RULE22 - with the R-C oscillator selected the half rate bit has no effect
// RULE23 - full rate E-clock: four conversions take 144 E-clock cycles
// RULE24 - half rate: four conversions take 288 E-clock cycles
// RULE25 - single channel, four conversions: results in slots 5..8 in order
// RULE26 - result slot: upper eight bits at one byte, low two in bits 7..6 of next
// RULE27 - after reset sequencer idles until the first control write
// RULE28 - each result slot is written in one clock so reads never see a partial value
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH
`define ACS_IDX_CTL 8'h30
`define ACS_IDX_RATE 8'h32
`define ACS_IDX_OPT 8'h39
`define ACS_IDX_RES_FIRST 8'h40
`define ACS_IDX_RES_LAST 8'h4f
`define ACS_BIT_DONE 7
`define ACS_BIT_EIGHT_CONVERSION_SELECT 6
`define ACS_BIT_SCAN 5
`define ACS_BIT_MULTI 4
`define ACS_BIT_HALF 0
`define ACS_BIT_PWR 7
`define ACS_BIT_CONVERSION_CLOCK_SOURCE 6
`define ACS_BIT_DLY 4
`define ACS_BIT_READY 0
`define ACS_RST_CTL 8'h00
`define ACS_RST_RATE 8'h00
`define ACS_RST_OPT 8'h00
`define ACS_SET4_TICKS 144
`define ACS_CONV_TICKS (`ACS_SET4_TICKS / 4)
`define ACS_SAMPLE_TICKS 12
`define ACS_RES_BITS 10
`define ACS_CLK_NS 5
`define ACS_PWR_SETTLE_NS 100000
`define ACS_PWR_SETTLE_CYC (`ACS_PWR_SETTLE_NS / `ACS_CLK_NS)
`endif

// ==== rtl/acs_pkg.sv ====
// Purpose: types shared by the conversion sequencer files
// Assumes: constants live in acs_params.svh
// Notes: none
package acs_pkg;
	typedef struct packed
	{
		logic eight_conversion_select;
		logic scan;
		logic multi;
		logic [3:0] chan;
	} acs_ctl_t;
	typedef struct packed
	{
		logic power_en;
		logic sample;
		logic [3:0] channel;
		logic [9:0] dac_code;
	} acs_ana_t;
	typedef enum logic [1:0] {ACS_IDLE, ACS_RUN, ACS_HOLD} acs_state_t;
endpackage

// ==== rtl/acs_result_bank.sv ====
// Purpose: eight ten-bit result slots
// Assumes: one writer, one combinational reader
// Notes: a slot is written whole in one clock
`timescale 1ns/1ps
`default_nettype none
module acs_result_bank
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [2:0] wr_slot,
	input wire logic [9:0] wr_data,
	input wire logic [2:0] rd_slot,
	output logic [9:0] rd_data
);
	import acs_pkg::*;
	logic [9:0] slot [0:7];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < 8; i++)
				slot[i] <= 10'h000;
		end
		else if (clk_en && wr_en)
			slot[wr_slot] <= wr_data; // RULE28
	end

	assign rd_data = slot[rd_slot];
endmodule // acs_result_bank
`default_nettype wire

// ==== bench/acs_sequencer_sva.sv ====
// Purpose: port checker for acs_sequencer
// Assumes: clk_en high during checked transfers
// Notes: bound after the module
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_sva
#(
	parameter int PWR_SETTLE_CYC = 20
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rc_tick,
	input wire logic low_power,
	input wire logic cmp_above,
	input wire acs_pkg::acs_ana_t analog_out
);
	import acs_pkg::*;
	logic seen_wr;
	wire rd = pready && !pwrite;
	wire ctl_wr = psel && penable && pready && pwrite && clk_en && paddr == 12'h0c0;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// first control write arms the sequencer
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			seen_wr <= 1'b0;
		else if (ctl_wr)
			seen_wr <= 1'b1;
	property p_ready;
		psel && penable && !pready && clk_en |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_ctl_ok;
		pready && paddr == 12'h0c0 |-> !pslverr;
	endproperty
	a_ctl_ok: assert property (p_ctl_ok) else $error("ctl error");
	property p_rate;
		rd && paddr == 12'h0c8 |-> prdata[31:1] == 31'h0;
	endproperty
	a_rate: assert property (p_rate) else $error("rate bits");
	property p_low;
		rd && paddr[11:8] == 4'h1 && paddr[2] |-> prdata[31:8] == 24'h0 && prdata[5:0] == 6'h0;
	endproperty
	a_low: assert property (p_low) else $error("low byte");
	property p_idle;
		!seen_wr |-> !analog_out.sample;
	endproperty
	a_idle: assert property (p_idle) else $error("early run");
	property p_power;
		(!analog_out.power_en)[*3] |-> !analog_out.sample;
	endproperty
	a_power: assert property (p_power) else $error("unpowered");
	property p_suspend;
		low_power[*3] |-> !analog_out.sample;
	endproperty
	a_suspend: assert property (p_suspend) else $error("not held");
	property p_abort;
		ctl_wr && analog_out.power_en && !low_power ##1 !low_power |=> analog_out.sample;
	endproperty
	a_abort: assert property (p_abort) else $error("no restart");
	c_done: cover property (rd && paddr == 12'h0c0 && prdata[7]);
	c_err: cover property (pready && pslverr);
	c_hold: cover property (low_power[*3]);
endmodule // acs_sequencer_sva
bind acs_sequencer acs_sequencer_sva #(.PWR_SETTLE_CYC(PWR_SETTLE_CYC)) acs_sequencer_sva_inst (.pclk(pclk),
	.presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick),
	.low_power(low_power), .cmp_above(cmp_above), .analog_out(analog_out));
`default_nettype wire

// ==== bench/acs_cmp_model.sv ====
// Purpose: analog multiplexer and comparator stand-in
// Assumes: every channel sits at level {channel, 6'h15}
// Notes: unpowered output toggles so it never looks valid
`timescale 1ns/1ps
`default_nettype none
module acs_cmp_model
(
	input wire logic pclk,
	input wire acs_pkg::acs_ana_t ana,
	output logic cmp_above
);
	import acs_pkg::*;
	logic [9:0] held = 10'h0;
	logic flip = 1'b0;
	always @(posedge pclk)
	begin
		flip <= ~flip;
		if (ana.sample)
			held <= {ana.channel, 6'h15};
	end
	// at-or-above so the search lands on the level itself
	assign cmp_above = ana.power_en ? held >= ana.dac_code : flip;
endmodule // acs_cmp_model
`default_nettype wire

// ==== bench/adc_conversion_sequencer_tb.sv ====
// Purpose: self-checking bench for acs_sequencer
// Assumes: model level is {channel, 6'h15}
// Notes: clk_en high except a 12-cycle pause in each scan test; settling cut to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb;
	import acs_pkg::*;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, rc_tick, low_power, cmp_above, rc_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [33:0] got_e;
	logic [7:0] c;
	acs_ana_t ana;
	acs_ana_t snap;
	logic [33:0] exp_q[$];
	int n_mismatch, num_checks, cyc, rcs;
	acs_sequencer #(.PWR_SETTLE_CYC(20)) acs_sequencer_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rc_tick(rc_tick), .low_power(low_power), .cmp_above(cmp_above),
		.analog_out(ana));
	acs_cmp_model acs_cmp_model_inst (.pclk(pclk), .ana(ana), .cmp_above(cmp_above));
	initial
	begin
		pclk = 1'b0;
		forever
			#2.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		rc_tick <= rc_on && (cyc % 3 == 0);
		rcs <= rcs + int'(rc_tick);
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		num_checks++;
		if (got !== want)
		begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic stuck;
		n_mismatch++;
		wrap_up();
	endtask
	// expectation noted first; the monitor pops it when pready lands
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
		int n;
		n = 0;
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			if (++n > 20)
				stuck();
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] v);
		xfer(1'b0, a, 32'h0, {2'b10, v});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		xfer(1'b1, a, v, 34'h0);
	endtask
	always @(posedge pclk)
		if (psel && penable && pready)
		begin
			if (exp_q.size() == 0)
				stuck();
			got_e = exp_q.pop_front();
			cmp(32'(pslverr), 32'(got_e[32]));
			if (got_e[33])
				cmp(prdata, got_e[31:0]);
		end
	task automatic wait_sample(input int lim);
		int n;
		n = 0;
		while (ana.sample !== 1'b1)
		begin
			if (++n > lim)
				stuck();
			@(posedge pclk);
		end
		cmp(32'(ana.sample), 32'h1);
	endtask
	// poll cost is a few cycles, hence the slack in the window
	task automatic run(input logic [7:0] cv, input int ticks, input logic rc);
		int t0, dt, n;
		n = 0;
		t0 = rc ? rcs : cyc;
		wr(12'h0c0, {24'h0, cv});
		xfer(1'b0, 12'h0c0, 32'h0, 34'h0);
		while (prdata[7] !== 1'b1)
		begin
			if (++n > 300)
				stuck();
			xfer(1'b0, 12'h0c0, 32'h0, 34'h0);
		end
		dt = (rc ? rcs : cyc) - t0;
		cmp(32'(dt >= ticks && dt <= ticks + 20), 32'h1);
	endtask
	task automatic slots(input logic [7:0] cv);
		logic [9:0] v;
		logic [3:0] ch;
		int s;
		for (int k = 0; k < (cv[6] ? 8 : 4); k++)
		begin
			ch = !cv[4] ? cv[3:0] : cv[6] ? {cv[3], 3'(k)} : {cv[3:2], 2'(k)};
			v = {ch, 6'h15};
			s = cv[6] ? k : k + 4;
			rd(12'(12'h100 + 8 * s), {24'h0, v[9:2]});
			rd(12'(12'h104 + 8 * s), {24'h0, v[1:0], 6'h0});
		end
	endtask
	initial
	begin
		{psel, penable, pwrite, low_power, rc_on} = '0;
		paddr = '0;
		pwdata = '0;
		clk_en = 1'b1;
		presetn = 1'b0;
		void'($urandom(27));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h0c0, 32'h0);
		rd(12'h0c8, 32'h0);
		xfer(1'b0, 12'h004, 32'h0, {2'b11, 32'h0});
		wr(12'h0c8, 32'hff);
		rd(12'h0c8, 32'h1);
		wr(12'h100, 32'hff);
		wr(12'h0e4, 32'h80);
		repeat (30) @(posedge pclk);
		rd(12'h0e4, 32'h81);
		$display("test registers done");
		for (int m = 0; m < 8; m++)
		begin
			c = {1'b0, m[1], 1'b0, m[0], 4'($urandom)};
			wr(12'h0c8, 32'(m[2]));
			run(c, (m[1] ? 288 : 144) * (m[2] ? 2 : 1), 1'b0);
			rd(12'h0c0, {24'h0, 1'b1, c[6:0]});
			repeat (60) @(posedge pclk);
			cmp(32'(ana.sample), 32'h0);
			slots(c);
			$display("test mode %0d done", m);
		end
		wr(12'h0c8, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			c = k ? 8'h3b : {4'h6, 4'($urandom)};
			run(c, k ? 144 : 288, 1'b0);
			repeat (400) @(posedge pclk);
			wait_sample(40);
			clk_en <= 1'b0;
			repeat (2) @(posedge pclk);
			snap = ana;
			repeat (10) @(posedge pclk);
			cmp(32'(ana), 32'(snap));
			clk_en <= 1'b1;
			rd(12'h0c0, {24'h0, 1'b1, c[6:0]});
			slots(c);
			$display("test scan %0d done", k);
		end
		run(8'h7c, 288, 1'b0);
		wait_sample(40);
		low_power <= 1'b1;
		repeat (20) @(posedge pclk);
		cmp(32'(ana.sample), 32'h0);
		low_power <= 1'b0;
		wait_sample(10);
		repeat (20) @(posedge pclk);
		slots(8'h7c);
		rd(12'h0c0, 32'hfc);
		wr(12'h0c0, 32'h05);
		rd(12'h0c0, 32'h05);
		wr(12'h0e4, 32'h0);
		repeat (5) @(posedge pclk);
		cmp(32'(ana.sample), 32'h0);
		$display("test continuous done");
		wr(12'h0e4, 32'hc0);
		repeat (20) @(posedge pclk);
		wr(12'h0c8, 32'h1);
		rc_on <= 1'b1;
		run(8'h13, 144, 1'b1);
		slots(8'h13);
		$display("test oscillator done");
		wrap_up();
	end
endmodule // adc_conversion_sequencer_tb
`default_nettype wire
